// ### src/drive_timing_decode.sv
`timescale 1ns/10ps
`include "ide_cfg_defs.svh"
module drive_timing_decode
   import ide_cfg_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // selections in, timing out
   timing_sel_if.decode sel
);

   // ----------------------------------------
   // per-drive decode
   // ----------------------------------------
   function automatic drive_timing_t decode_timing(input logic base, input logic fast,
                                                   input logic [1:0] code);
      drive_timing_t t;
      t = '0;
      if (fast) begin
         t.base = base_133;
         if (code == `CT_CODE_1) begin
            t.valid = 1'b1;
            t.strobe = `STB_133_C1;
            t.stop = `STOP_133_C1;
         end
      end else if (base) begin
         t.base = base_66;
         case (code)
            `CT_CODE_1: begin
               t.valid = 1'b1;
               t.strobe = `STB_66_C1;
               t.stop = `STOP_66_C1;
            end
            `CT_CODE_2: begin
               t.valid = 1'b1;
               t.strobe = `STB_66_C2;
               t.stop = `STOP_66_C2;
            end
            default: t.valid = 1'b0;
         endcase
      end else begin
         t.base = base_33;
         case (code)
            `CT_CODE_0: begin
               t.valid = 1'b1;
               t.strobe = `STB_33_C0;
               t.stop = `STOP_33_C0;
            end
            `CT_CODE_1: begin
               t.valid = 1'b1;
               t.strobe = `STB_33_C1;
               t.stop = `STOP_33_C1;
            end
            `CT_CODE_2: begin
               t.valid = 1'b1;
               t.strobe = `STB_33_C2;
               t.stop = `STOP_33_C2;
            end
            default: t.valid = 1'b0;
         endcase
      end
      return t;
   endfunction

   genvar d;
   generate
      for (d = 0; d < 4; d++) begin : g_drive
         drive_timing_t timing_reg;
         drive_timing_t timing_next;

         always_comb begin
            timing_next = decode_timing(sel.base_clock[d], sel.fast_clock[d],
                                        sel.cycle_time[d]);
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               timing_reg <= '0;
            end else begin
               timing_reg <= timing_next;
            end
         end

         assign sel.timing[d] = timing_reg;

         a_reserved_no_count: assert property (@(posedge pclk) disable iff (!presetn)
            (sel.fast_clock[d] && sel.cycle_time[d] != `CT_CODE_1)
            |=> (!timing_reg.valid && timing_reg.strobe == 4'h0))
            else $error("reserved fast code gave a timing");
      end
   endgenerate

endmodule

// ### src/ide_cfg_defs.svh
`ifndef IDE_CFG_DEFS_SVH
`define IDE_CFG_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define IDE_CFG_OFFSET 12'h054
`define IDE_CFG_RESET 32'h0000_0000
`define IDE_CFG_WR_MASK 32'h000F_F4FF

// ----------------------------------------
// field positions
// ----------------------------------------
`define SEC_PIN_MODE_HI 19
`define SEC_PIN_MODE_LO 18
`define PRI_PIN_MODE_HI 17
`define PRI_PIN_MODE_LO 16
`define FAST_CLOCK_HI 15
`define FAST_CLOCK_LO 12
`define SPLIT_BUF_BIT 10
`define CABLE_HI 7
`define CABLE_LO 4
`define BASE_CLOCK_HI 3
`define BASE_CLOCK_LO 0

// ----------------------------------------
// pin mode codes
// ----------------------------------------
`define PIN_MODE_NORMAL 2'h0
`define PIN_MODE_TRISTATE 2'h1
`define PIN_MODE_DRIVE_LOW 2'h2

// ----------------------------------------
// cycle time codes and counts in clocks
// ----------------------------------------
`define CT_CODE_0 2'h0
`define CT_CODE_1 2'h1
`define CT_CODE_2 2'h2
`define STB_33_C0 4'h4
`define STOP_33_C0 5'h06
`define STB_33_C1 4'h3
`define STOP_33_C1 5'h05
`define STB_33_C2 4'h2
`define STOP_33_C2 5'h04
`define STB_66_C1 4'h3
`define STOP_66_C1 5'h08
`define STB_66_C2 4'h2
`define STOP_66_C2 5'h08
`define STB_133_C1 4'h3
`define STOP_133_C1 5'h10

`endif

// ### src/ide_cfg_pkg.sv
package ide_cfg_pkg;

   typedef enum logic [1:0] {
      base_33,
      base_66,
      base_133
   } timing_base_t;

   typedef struct packed {
      timing_base_t base;
      logic valid;
      logic [3:0] strobe;
      logic [4:0] stop;
   } drive_timing_t;

endpackage

// ### src/ide_io_config_register.sv
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "ide_cfg_defs.svh"
module ide_io_config_register
   import ide_cfg_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // per-drive cycle time codes
   input wire logic [1:0] pri_drive0_cycle_time,
   input wire logic [1:0] pri_drive1_cycle_time,
   input wire logic [1:0] sec_drive0_cycle_time,
   input wire logic [1:0] sec_drive1_cycle_time,
   // per-drive timing, index 0 pri d0, 1 pri d1, 2 sec d0, 3 sec d1
   output timing_base_t [3:0] timing_base,
   output logic [3:0] timing_code_valid,
   output logic [3:0][3:0] strobe_cycle_time,
   output logic [3:0][4:0] ready_to_stop_time,
   // channel control, index 0 primary, 1 secondary
   input wire logic [1:0] xfer_start_req,
   output logic [1:0] xfer_start,
   input wire logic [1:0][15:0] chan_pins_in,
   output logic [1:0][15:0] chan_pins_seen,
   output logic [1:0] channel_enabled,
   output logic [1:0] pad_tristate,
   output logic [1:0] pad_drive_low,
   // buffer and cable
   output logic split_write_buffer_enable,
   output logic [3:0] cable_80_conductor
);

   // ----------------------------------------
   // pin mode decode
   // ----------------------------------------
   // returns {enabled, tristate, drive_low}; reserved 11 is parked tri-stated,
   // the safe choice for a bay that may be empty
   function automatic logic [2:0] decode_pin_mode(input logic [1:0] mode);
      logic [2:0] r;
      r = 3'h0;
      case (mode)
         `PIN_MODE_NORMAL: r = 3'h4;
         `PIN_MODE_TRISTATE: r = 3'h2;
         `PIN_MODE_DRIVE_LOW: r = 3'h1;
         default: r = 3'h2;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // apb register state
   // ----------------------------------------
   logic [31:0] config_reg;
   logic [31:0] config_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [1:0][2:0] pad_reg;
   logic [1:0][2:0] pad_next;
   logic [1:0][15:0] pins_reg;
   logic [1:0][15:0] pins_next;
   logic addr_hit;
   logic wr_access;
   logic rd_setup;
   logic [31:0] byte_mask;

   assign addr_hit = (paddr == `IDE_CFG_OFFSET);
   assign wr_access = psel && penable && pwrite && addr_hit;
   assign rd_setup = psel && !penable && !pwrite;

   always_comb begin
      byte_mask = '0;
      for (int b = 0; b < 4; b++) begin
         byte_mask[b*8 +: 8] = {8{pstrb[b]}};
      end
      config_next = config_reg;
      if (wr_access) begin
         // reserved bits never latch
         config_next = (config_reg & ~(byte_mask & `IDE_CFG_WR_MASK))
                     | (pwdata & byte_mask & `IDE_CFG_WR_MASK);
      end
      prdata_next = prdata_reg;
      if (rd_setup) begin
         prdata_next = addr_hit ? config_reg : 32'h0000_0000;
      end
      pad_next[0] = decode_pin_mode(config_next[`PRI_PIN_MODE_HI:`PRI_PIN_MODE_LO]);
      pad_next[1] = decode_pin_mode(config_next[`SEC_PIN_MODE_HI:`SEC_PIN_MODE_LO]);
      for (int c = 0; c < 2; c++) begin
         // disabled channel sees quiet pins
         pins_next[c] = pad_reg[c][2] ? chan_pins_in[c] : 16'h0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= `IDE_CFG_RESET;
         prdata_reg <= 32'h0000_0000;
         pad_reg <= {3'h4, 3'h4};
         pins_reg <= '0;
      end else begin
         config_reg <= config_next;
         prdata_reg <= prdata_next;
         pad_reg <= pad_next;
         pins_reg <= pins_next;
      end
   end

   assign prdata = prdata_reg;
   // zero wait state slave
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;

   // ----------------------------------------
   // channel and pad outputs
   // ----------------------------------------
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_chan
         assign channel_enabled[c] = pad_reg[c][2];
         assign pad_tristate[c] = pad_reg[c][1];
         assign pad_drive_low[c] = pad_reg[c][0];
         assign xfer_start[c] = xfer_start_req[c] && pad_reg[c][2];
      end
   endgenerate
   assign chan_pins_seen = pins_reg;

   assign split_write_buffer_enable = config_reg[`SPLIT_BUF_BIT];
   assign cable_80_conductor = config_reg[`CABLE_HI:`CABLE_LO];

   // ----------------------------------------
   // drive timing selection
   // ----------------------------------------
   timing_sel_if sel ();

   assign sel.base_clock = config_reg[`BASE_CLOCK_HI:`BASE_CLOCK_LO];
   assign sel.fast_clock = config_reg[`FAST_CLOCK_HI:`FAST_CLOCK_LO];
   assign sel.cycle_time = {sec_drive1_cycle_time, sec_drive0_cycle_time,
                            pri_drive1_cycle_time, pri_drive0_cycle_time};

   drive_timing_decode u_decode (
      .pclk(pclk),
      .presetn(presetn),
      .sel(sel)
   );

   genvar d;
   generate
      for (d = 0; d < 4; d++) begin : g_out
         assign timing_base[d] = sel.timing[d].base;
         assign timing_code_valid[d] = sel.timing[d].valid;
         assign strobe_cycle_time[d] = sel.timing[d].strobe;
         assign ready_to_stop_time[d] = sel.timing[d].stop;
      end
   endgenerate

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_reserved_reads_zero: assert property (
      (config_reg & ~`IDE_CFG_WR_MASK) == 32'h0000_0000)
      else $error("reserved bit of config register is set");

   a_full_write_lands: assert property (
      (wr_access && pstrb == 4'hF)
      |=> config_reg == ($past(pwdata) & `IDE_CFG_WR_MASK))
      else $error("full write did not land in config register");

   a_read_after_setup: assert property (
      (rd_setup && addr_hit) |=> prdata == $past(config_reg) && prdata[7:4] == cable_80_conductor)
      else $error("read data does not match config register");

   a_sec_tristate: assert property (
      config_reg[19:18] == `PIN_MODE_TRISTATE
      |-> pad_tristate[1] && !pad_drive_low[1] && !channel_enabled[1])
      else $error("secondary tri-state mode not applied");

   a_sec_drive_low: assert property (
      config_reg[19:18] == `PIN_MODE_DRIVE_LOW |-> pad_drive_low[1] && !pad_tristate[1])
      else $error("secondary drive-low mode not applied");

   a_pri_mode_map: assert property (
      (config_reg[17:16] == `PIN_MODE_NORMAL |-> channel_enabled[0] && !pad_tristate[0])
      and (config_reg[17:16] == `PIN_MODE_DRIVE_LOW |-> pad_drive_low[0] && !channel_enabled[0]))
      else $error("primary pin mode not applied");

   a_fast_sec1: assert property (
      config_reg[15] |=> timing_base[3] == base_133)
      else $error("secondary drive 1 fast clock ignored");

   a_fast_sec0: assert property (
      config_reg[14] && config_reg[2] |=> timing_base[2] == base_133)
      else $error("secondary drive 0 fast clock did not override base");

   a_fast_pri1: assert property (
      config_reg[13] && !$past(config_reg[13]) |=> timing_base[1] == base_133)
      else $error("primary drive 1 fast clock ignored");

   a_fast_pri0: assert property (
      config_reg[12] ##1 config_reg[12] |=> timing_base[0] == base_133)
      else $error("primary drive 0 fast clock ignored");

   a_base_select: assert property (
      !config_reg[12] |=> timing_base[0] == ($past(config_reg[0]) ? base_66 : base_33))
      else $error("primary drive 0 base clock wrong");

   a_split_follows: assert property (
      wr_access && pstrb[1] |=> split_write_buffer_enable == $past(pwdata[10]))
      else $error("split buffer enable did not follow write");

   a_33_code0: assert property (
      !config_reg[12] && !config_reg[0] && pri_drive0_cycle_time == `CT_CODE_0
      |=> strobe_cycle_time[0] == 4'h4 && ready_to_stop_time[0] == 5'h06)
      else $error("33 MHz code 0 timing wrong");

   a_66_code2: assert property (
      !config_reg[13] && config_reg[1] && pri_drive1_cycle_time == `CT_CODE_2
      |=> strobe_cycle_time[1] == 4'h2 && ready_to_stop_time[1] == 5'h08)
      else $error("66 MHz code 2 timing wrong");

   a_66_code0_void: assert property (
      !config_reg[13] && config_reg[1] && pri_drive1_cycle_time == `CT_CODE_0
      |=> !timing_code_valid[1])
      else $error("66 MHz code 0 not reserved");

   a_133_code1: assert property (
      config_reg[14] && sec_drive0_cycle_time == `CT_CODE_1
      |=> strobe_cycle_time[2] == 4'h3 && ready_to_stop_time[2] == 5'h10 && timing_code_valid[2])
      else $error("133 MHz code 1 timing wrong");

   a_disabled_no_xfer: assert property (
      !channel_enabled[1] |-> !xfer_start[1])
      else $error("disabled secondary channel started a transfer");

   a_disabled_no_pins: assert property (
      !channel_enabled[1] |=> chan_pins_seen[1] == 16'h0000)
      else $error("disabled secondary channel saw its pins");

   a_pri_no_xfer: assert property (
      !channel_enabled[0] |-> !xfer_start[0])
      else $error("disabled primary channel started a transfer");

   a_pri_no_pins: assert property (
      !channel_enabled[0] |=> chan_pins_seen[0] == 16'h0000)
      else $error("disabled primary channel saw its pins");

   a_pri_pins_pass: assert property (
      channel_enabled[0] |=> chan_pins_seen[0] == $past(chan_pins_in[0]))
      else $error("enabled primary channel lost its pins");

   a_sec_start_pass: assert property (
      channel_enabled[1] && xfer_start_req[1] |-> xfer_start[1])
      else $error("enabled secondary channel blocked a transfer");

   a_sec_normal_map: assert property (
      config_reg[19:18] == `PIN_MODE_NORMAL
      |-> channel_enabled[1] && !pad_tristate[1] && !pad_drive_low[1])
      else $error("secondary normal mode not applied");

   a_sec_mode_park: assert property (
      config_reg[19:18] == 2'h3 |-> pad_tristate[1] && !channel_enabled[1])
      else $error("secondary reserved mode not parked");

   a_pri_tristate: assert property (
      config_reg[17:16] == `PIN_MODE_TRISTATE
      |-> pad_tristate[0] && !pad_drive_low[0] && !channel_enabled[0])
      else $error("primary tri-state mode not applied");

   a_pri_mode_park: assert property (
      config_reg[17:16] == 2'h3 |-> pad_tristate[0] && !channel_enabled[0])
      else $error("primary reserved mode not parked");

   a_fast_sec1_code: assert property (
      config_reg[15] && sec_drive1_cycle_time == `CT_CODE_1
      |=> strobe_cycle_time[3] == 4'h3 && ready_to_stop_time[3] == 5'h10)
      else $error("secondary drive 1 fast timing wrong");

   a_fast_pri0_void: assert property (
      config_reg[12] && pri_drive0_cycle_time != `CT_CODE_1
      |=> !timing_code_valid[0] && ready_to_stop_time[0] == 5'h00)
      else $error("primary drive 0 reserved fast code gave a timing");

   a_base_sec1: assert property (
      !config_reg[15] |=> timing_base[3] == ($past(config_reg[3]) ? base_66 : base_33))
      else $error("secondary drive 1 base clock wrong");

   a_base_pri1: assert property (
      !config_reg[13] |=> timing_base[1] == ($past(config_reg[1]) ? base_66 : base_33))
      else $error("primary drive 1 base clock wrong");

   a_split_holds: assert property (
      !(wr_access && pstrb[1]) |=> $stable(split_write_buffer_enable))
      else $error("split buffer enable changed without a write");

   a_cable_follows: assert property (
      wr_access && pstrb[0] |=> cable_80_conductor == $past(pwdata[7:4]))
      else $error("cable bits did not follow write");

   a_cable_holds: assert property (
      !(wr_access && pstrb[0]) |=> $stable(cable_80_conductor))
      else $error("cable bits changed without a write");

   a_unmapped_no_write: assert property (
      psel && penable && pwrite && !addr_hit |=> $stable(config_reg))
      else $error("unmapped write changed config register");

   a_setup_no_write: assert property (
      psel && !penable |=> $stable(config_reg))
      else $error("config register changed in setup cycle");

   a_unmapped_reads_zero: assert property (
      rd_setup && !addr_hit |=> prdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_unmapped_error: assert property (
      psel && penable && !addr_hit |-> pslverr && pready)
      else $error("unmapped access not flagged");

   c_write_read: cover property (wr_access ##[1:4] (rd_setup && addr_hit));
   c_sec_tristate: cover property (config_reg[19:18] == `PIN_MODE_TRISTATE && xfer_start_req[1]);
   c_fast_timing: cover property (timing_base[3] == base_133 && timing_code_valid[3]);
   c_unmapped: cover property (pslverr);
   c_pri_drive_low: cover property (pad_drive_low[0]);

endmodule

// ### src/timing_sel_if.sv
`timescale 1ns/10ps
interface timing_sel_if;
   import ide_cfg_pkg::*;
   logic [3:0] base_clock;
   logic [3:0] fast_clock;
   logic [3:0][1:0] cycle_time;
   drive_timing_t [3:0] timing;

   modport cfg (
      output base_clock,
      output fast_clock,
      output cycle_time,
      input timing
   );
   modport decode (
      input base_clock,
      input fast_clock,
      input cycle_time,
      output timing
   );
endinterface

// ### testbench/drive_side_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// drive side: cycle codes, requests, pins
// ----------------------------------------
module drive_side_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // settings from the bench
   input wire logic [1:0] code_set,
   input wire logic [1:0] req_set,
   // toward the block
   output logic [1:0] pri_drive0_cycle_time,
   output logic [1:0] pri_drive1_cycle_time,
   output logic [1:0] sec_drive0_cycle_time,
   output logic [1:0] sec_drive1_cycle_time,
   output logic [1:0] xfer_start_req,
   output logic [1:0][15:0] chan_pins_in
);
   logic [15:0] cnt_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // pins change every cycle, so a stale sample never matches
   assign chan_pins_in[0] = cnt_reg ^ 16'hA5A5;
   assign chan_pins_in[1] = ~cnt_reg;
   assign pri_drive0_cycle_time = code_set;
   assign pri_drive1_cycle_time = code_set;
   assign sec_drive0_cycle_time = code_set;
   assign sec_drive1_cycle_time = code_set;
   assign xfer_start_req = req_set;
endmodule

// ### testbench/test_ide_io_config_register.sv
`timescale 1ns/10ps
module test_ide_io_config_register
   import ide_cfg_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, split_write_buffer_enable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, timing_code_valid, cable_80_conductor;
   logic [1:0] c0, c1, c2, c3, code_set, req_set, xfer_start_req, xfer_start;
   logic [1:0] channel_enabled, pad_tristate, pad_drive_low;
   logic [1:0][15:0] chan_pins_in, chan_pins_seen, p;
   timing_base_t [3:0] timing_base;
   logic [3:0][3:0] strobe_cycle_time;
   logic [3:0][4:0] ready_to_stop_time;
   logic er;
   int err_total = 0;
   int cmp_count = 0;
   localparam logic [3:0] base_tab [6] = '{4'h5, 4'h0, 4'hF, 4'h0, 4'hF, 4'h3};
   localparam logic [3:0] fast_tab [6] = '{4'h0, 4'hA, 4'h5, 4'h0, 4'h0, 4'hC};
   localparam logic [1:0] code_tab [6] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h1, 2'h3};

   ide_io_config_register dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pri_drive0_cycle_time(c0),
      .pri_drive1_cycle_time(c1), .sec_drive0_cycle_time(c2), .sec_drive1_cycle_time(c3),
      .timing_base(timing_base), .timing_code_valid(timing_code_valid),
      .strobe_cycle_time(strobe_cycle_time), .ready_to_stop_time(ready_to_stop_time),
      .xfer_start_req(xfer_start_req), .xfer_start(xfer_start), .chan_pins_in(chan_pins_in),
      .chan_pins_seen(chan_pins_seen), .channel_enabled(channel_enabled),
      .pad_tristate(pad_tristate), .pad_drive_low(pad_drive_low),
      .split_write_buffer_enable(split_write_buffer_enable),
      .cable_80_conductor(cable_80_conductor));

   drive_side_model drive (.pclk(pclk), .presetn(presetn), .code_set(code_set),
      .req_set(req_set), .pri_drive0_cycle_time(c0), .pri_drive1_cycle_time(c1),
      .sec_drive0_cycle_time(c2), .sec_drive1_cycle_time(c3),
      .xfer_start_req(xfer_start_req), .chan_pins_in(chan_pins_in));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // read data and error taken at the edge that ends the access
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic [11:0] exp_t(input logic b, input logic f, input logic [1:0] c);
      logic [1:0] base;
      logic [8:0] cnt;
      base = f ? 2'h2 : {1'b0, b};
      case ({base, c})
         4'h0: cnt = {4'h4, 5'h06};
         4'h1: cnt = {4'h3, 5'h05};
         4'h2: cnt = {4'h2, 5'h04};
         4'h5: cnt = {4'h3, 5'h08};
         4'h6: cnt = {4'h2, 5'h08};
         4'h9: cnt = {4'h3, 5'h10};
         default: cnt = 9'h000;
      endcase
      return {base, cnt != 9'h000, cnt};
   endfunction

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      apb(1'b0, 12'h054, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_0000);
      chk({channel_enabled, split_write_buffer_enable, cable_80_conductor}, 32'h60);
      $display("test reset done");
   endtask

   task automatic test_reg();
      apb(1'b1, 12'h054, 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, 12'h054, 32'h0000_0000, 4'hF);
      chk(rd, 32'h000F_F4FF);
      chk({split_write_buffer_enable, cable_80_conductor}, 32'h1F);
      // firmware reports mixed cables per drive
      apb(1'b1, 12'h054, 32'h0000_0050, 4'hF);
      #1 chk({split_write_buffer_enable, cable_80_conductor}, 32'h05);
      apb(1'b1, 12'h054, 32'hFFFF_FFFF, 4'h2);
      apb(1'b0, 12'h054, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_F450);
      apb(1'b1, 12'h058, 32'h0000_0000, 4'hF);
      chk(er, 1'b1);
      apb(1'b0, 12'h050, 32'h0000_0000, 4'hF);
      chk(er, 1'b1);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h054, 32'h0000_0000, 4'hF);
      chk(er, 1'b0);
      chk(rd, 32'h0000_F450);
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h054, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_0000);
      $display("test reg done");
   endtask

   task automatic test_pins();
      logic [1:0] pm, sm, en;
      for (int m = 0; m < 4; m++) begin
         pm = 2'(m);
         sm = 2'(m + 1);
         en = {sm == 2'h0, pm == 2'h0};
         @(posedge pclk);
         req_set <= ~2'(m);
         // board keeps normal mode only where a drive is fitted
         apb(1'b1, 12'h054, {12'h000, sm, pm, 16'h0000}, 4'hF);
         @(posedge pclk);
         #1 p = chan_pins_in;
         @(posedge pclk);
         #1 chk(channel_enabled, en);
         chk(pad_tristate, {sm[0], pm[0]});
         chk(pad_drive_low, {sm == 2'h2, pm == 2'h2});
         chk(xfer_start, en & ~2'(m));
         chk(chan_pins_seen, {en[1] ? p[1] : 16'h0000, en[0] ? p[0] : 16'h0000});
      end
      $display("test pins done");
   endtask

   task automatic test_timing();
      for (int k = 0; k < 6; k++) begin
         @(posedge pclk);
         code_set <= code_tab[k];
         apb(1'b1, 12'h054, {16'h0000, fast_tab[k], 8'h00, base_tab[k]}, 4'hF);
         repeat (2) @(posedge pclk);
         #1;
         for (int i = 0; i < 4; i++) begin
            chk({timing_base[i], timing_code_valid[i], strobe_cycle_time[i],
                 ready_to_stop_time[i]}, exp_t(base_tab[k][i], fast_tab[k][i],
                 code_tab[k]));
         end
      end
      $display("test timing done");
   endtask

   // ----------------------------------------
   // clock, reset, sequence, watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      code_set = 2'h0;
      req_set = 2'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_reg();
      test_pins();
      test_timing();
      test_done();
   end

   initial begin
      #100us;
      err_total++;
      test_done();
   end
endmodule
